// ---- dv/sob_loader_asserts.sv ----
/* Port checker for the option byte loader.
   Assumes it is bound to sob_loader and shares its clock. */
`timescale 1ns/100ps
module sob_loader_chk (
  // Clock, reset and read port
  input wire logic clock,
  input wire logic resetn,
  input wire logic xdata_rd,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_rvalid,
  input wire logic xdata_hit,
  input wire logic [7:0] xdata_rdata,
  // Held options
  input wire logic options_valid,
  input wire logic watchdog_clock_select,
  input wire logic reset_pin_off,
  input wire logic port_reset_level,
  input wire logic [7:0] port_reset_value,
  input wire logic crystal_filter_enable,
  input wire sob_pkg::sob_osc_t osc_source,
  input wire logic osc_reserved,
  input wire logic program_read_blocked,
  input wire logic data_read_blocked,
  input wire logic lock_unsupported,
  input wire logic pwm_hz_even,
  input wire logic pwm_hz_odd
);
  import sob_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic mapped;
  logic low_rd;
  assign mapped = xdata_addr == 16'hFB00 || xdata_addr == 16'hFB01;
  assign low_rd = xdata_rd && xdata_addr == 16'hFB00 && options_valid;
  a_read_answer: assert property (xdata_rd |=> xdata_rvalid)
    else $error("no read answer");
  a_rvalid_pulse: assert property (!xdata_rd |=> !xdata_rvalid && xdata_rdata == 8'h00)
    else $error("read answer without request");
  a_read_hit: assert property (xdata_rd && mapped |=> xdata_hit)
    else $error("option address missed");
  a_read_miss: assert property (xdata_rd && !mapped |=> !xdata_hit && xdata_rdata == 8'h00)
    else $error("unmapped read answered");
  a_low_fields: assert property (low_rd |=> xdata_rdata[7:5] ==
    {watchdog_clock_select, reset_pin_off, port_reset_level} &&
    xdata_rdata[2:0] == {crystal_filter_enable, osc_source})
    else $error("low byte read differs from fields");
  a_high_fields: assert property (xdata_rd && xdata_addr == 16'hFB01 && options_valid |=>
    xdata_rdata[7:6] == ~{program_read_blocked, data_read_blocked} &&
    xdata_rdata[1:0] == {pwm_hz_even, pwm_hz_odd})
    else $error("high byte read differs from fields");
  a_port_value: assert property (options_valid |-> port_reset_value == {8{port_reset_level}})
    else $error("port reset value wrong");
  a_lock_flag: assert property (options_valid |->
    lock_unsupported == (!program_read_blocked && data_read_blocked))
    else $error("unsupported lock flag wrong");
  a_osc_reserved: assert property (options_valid |->
    osc_reserved == (osc_source == sob_osc_reserved))
    else $error("reserved clock flag wrong");
  a_options_hold: assert property (options_valid |=> options_valid && $stable({
    watchdog_clock_select, reset_pin_off, port_reset_value, osc_source, pwm_hz_even}))
    else $error("held options changed");
  a_capture_bound: assert property ($rose(resetn) |-> ##[4:8] options_valid)
    else $error("options not captured in time");
  c_hit: cover property (xdata_rd && mapped);
  c_miss: cover property (xdata_rd && !mapped);
  c_valid: cover property ($rose(options_valid));
  c_lock: cover property (lock_unsupported);
endmodule

bind sob_loader sob_loader_chk u_chk (.clock(clock), .resetn(resetn), .xdata_rd(xdata_rd),
  .xdata_addr(xdata_addr), .xdata_rvalid(xdata_rvalid), .xdata_hit(xdata_hit),
  .xdata_rdata(xdata_rdata), .options_valid(options_valid),
  .watchdog_clock_select(watchdog_clock_select), .reset_pin_off(reset_pin_off),
  .port_reset_level(port_reset_level), .port_reset_value(port_reset_value),
  .crystal_filter_enable(crystal_filter_enable), .osc_source(osc_source),
  .osc_reserved(osc_reserved), .program_read_blocked(program_read_blocked),
  .data_read_blocked(data_read_blocked), .lock_unsupported(lock_unsupported),
  .pwm_hz_even(pwm_hz_even), .pwm_hz_odd(pwm_hz_odd));

// ---- dv/sob_loader_tb_top.sv ----
/* Self-checking bench of the option byte loader.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/100ps
module sob_loader_tb_top;
  import sob_pkg::*;
  logic clock, resetn, xdata_rd, xdata_rvalid, xdata_hit, options_valid;
  logic [7:0] flash_lo, flash_hi, xdata_rdata, port_value;
  logic [15:0] xdata_addr;
  logic wdt, rst_off, port_lvl, filt, osc_rsv, p_blk, d_blk, lock_bad, hz_even, hz_odd;
  sob_bod_t bod;
  sob_osc_t osc;
  int fails, num_checks;
  logic [7:0] lo_tab [4] = '{8'h00, 8'h49, 8'hB6, 8'hFF};
  logic [7:0] hi_tab [4] = '{8'hC0, 8'h41, 8'h82, 8'h3F};

  sob_loader u_dut (.clock(clock), .resetn(resetn), .flash_options_low(flash_lo),
    .flash_options_high(flash_hi), .xdata_rd(xdata_rd), .xdata_addr(xdata_addr),
    .xdata_rvalid(xdata_rvalid), .xdata_hit(xdata_hit), .xdata_rdata(xdata_rdata),
    .options_valid(options_valid), .watchdog_clock_select(wdt), .reset_pin_off(rst_off),
    .port_reset_level(port_lvl), .port_reset_value(port_value),
    .brownout_level_select(bod), .crystal_filter_enable(filt), .osc_source(osc),
    .osc_reserved(osc_rsv), .program_read_blocked(p_blk), .data_read_blocked(d_blk),
    .lock_unsupported(lock_bad), .pwm_hz_even(hz_even), .pwm_hz_odd(hz_odd));

  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset(input logic [7:0] lo, input logic [7:0] hi);
    resetn = 0;
    flash_lo = lo;
    flash_hi = hi;
    repeat (12) @(negedge clock);
    check("valid_in_reset", options_valid, 0);
    check("rvalid_in_reset", xdata_rvalid, 0);
    resetn = 1;
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (options_valid !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check("options_valid", options_valid, 1);
  endtask

  // Leaves the strobe high so reads can follow back to back
  task automatic xread(input logic [15:0] a, input logic [7:0] exp, input logic h);
    xdata_rd = 1;
    xdata_addr = a;
    @(negedge clock);
    check("rvalid", xdata_rvalid, 1);
    check("hit", xdata_hit, h);
    check("rdata", xdata_rdata, exp);
  endtask

  task automatic check_fields(input logic [7:0] lo, input logic [7:0] hi);
    check("watchdog", wdt, lo[7]);
    check("reset_pin", rst_off, lo[6]);
    check("port_value", port_value, lo[5] ? 8'hFF : 8'h00);
    check("port_level", port_lvl, lo[5]);
    check("brownout", bod, lo[4] ? sob_bod_2v6 : lo[3] ? sob_bod_3v8 : sob_bod_4v5);
    check("filter", filt, lo[2]);
    check("osc", {osc_rsv, osc}, {lo[1:0] == 2'b10, lo[1:0]});
    check("locks", {p_blk, d_blk, lock_bad}, {~hi[7:6], hi[7:6] == 2'b10});
    check("pwm_hz", {hz_even, hz_odd}, hi[1:0]);
    xread(16'hFB00, lo, 1);
    xread(16'hFB01, hi, 1);
    xread(16'hFB02, 8'h00, 0);
    xdata_rd = 0;
    @(negedge clock);
    check("rvalid_end", xdata_rvalid, 0);
  endtask

  task automatic sc_decode();
    for (int i = 0; i < 4; i++) begin
      do_reset(lo_tab[i], hi_tab[i]);
      wait_valid();
      check_fields(lo_tab[i], hi_tab[i]);
    end
  endtask

  task automatic sc_hold();
    do_reset(8'h49, 8'h41);
    wait_valid();
    flash_lo = 8'hB6;
    flash_hi = 8'h82;
    repeat (10) @(negedge clock);
    check_fields(8'h49, 8'h41);
    do_reset(8'hB6, 8'h82);
    xread(16'hFB00, 8'hFF, 1);
    xdata_rd = 0;
    wait_valid();
    check_fields(8'hB6, 8'h82);
  endtask

  initial begin
    resetn = 0;
    xdata_rd = 0;
    xdata_addr = 16'h0000;
    flash_lo = 8'hFF;
    flash_hi = 8'hFF;
    @(negedge clock);
    sc_decode();
    sc_hold();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    give_verdict();
  end
endmodule

// ---- hw/sob_decode.sv ----
/*
  Combinational field decoder of the two held option bytes.
  Assumes the loader holds the bytes steady between resets.
*/
`timescale 1ns/100ps
`include "sob_params.svh"
module sob_decode (
  sob_opt_if.decoder opt
);
  import sob_pkg::*;

  logic osc_hi;
  logic osc_lo;

  assign osc_hi = opt.options_low[`SOB_OSC_HI_BIT];
  assign osc_lo = opt.options_low[`SOB_OSC_LO_BIT];

  always_comb begin
    opt.watchdog_clock_select = opt.options_low[`SOB_WDT_CLK_BIT];
    opt.reset_pin_off = opt.options_low[`SOB_RST_PIN_BIT];
    opt.port_reset_level = opt.options_low[`SOB_PORT_LVL_BIT];
    if (opt.options_low[`SOB_BOD_HI_BIT]) begin
      opt.brownout_level_select = sob_bod_2v6;
    end else if (opt.options_low[`SOB_BOD_LO_BIT]) begin
      opt.brownout_level_select = sob_bod_3v8;
    end else begin
      opt.brownout_level_select = sob_bod_4v5;
    end
    opt.crystal_filter_enable = opt.options_low[`SOB_XFILT_BIT];
    case ({osc_hi, osc_lo})
      2'b00: opt.osc_source = sob_osc_crystal;
      2'b01: opt.osc_source = sob_osc_internal_rc;
      2'b10: opt.osc_source = sob_osc_reserved;
      default: opt.osc_source = sob_osc_external;
    endcase
    // A clear lock bit blocks outside reads
    opt.program_read_blocked = ~opt.options_high[`SOB_PLOCK_BIT];
    opt.data_read_blocked = ~opt.options_high[`SOB_DLOCK_BIT];
    opt.lock_unsupported = opt.options_high[`SOB_PLOCK_BIT] &
                           ~opt.options_high[`SOB_DLOCK_BIT];
    opt.pwm_hz_even = opt.options_high[`SOB_HZ_EVEN_BIT];
    opt.pwm_hz_odd = opt.options_high[`SOB_HZ_ODD_BIT];
  end
endmodule

// ---- hw/sob_loader.sv ----
/*
  Start-up option byte loader: captures the two flash option bytes after
  reset, holds them until the next reset, decodes their fields and answers
  external data move reads at their addresses.
  Assumes the flash array drives the bytes as steady levels from another
  domain, and that flash programming itself lies outside this block.
*/
`timescale 1ns/100ps
`include "sob_params.svh"
module sob_loader (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Option bytes from the flash array
  input wire logic [7:0] flash_options_low,
  input wire logic [7:0] flash_options_high,
  // External data move read port
  input wire logic xdata_rd,
  input wire logic [15:0] xdata_addr,
  output logic xdata_rvalid,
  output logic xdata_hit,
  output logic [7:0] xdata_rdata,
  // Load status
  output logic options_valid,
  // Decoded clock and reset options
  output logic watchdog_clock_select,
  output logic reset_pin_off,
  output logic port_reset_level,
  output logic [7:0] port_reset_value,
  output sob_pkg::sob_bod_t brownout_level_select,
  output logic crystal_filter_enable,
  output sob_pkg::sob_osc_t osc_source,
  output logic osc_reserved,
  // Protection and PWM drive options
  output logic program_read_blocked,
  output logic data_read_blocked,
  output logic lock_unsupported,
  output logic pwm_hz_even,
  output logic pwm_hz_odd
);
  import sob_pkg::*;

  sob_opt_if opt ();

  sob_decode u_decode (
    .opt(opt.decoder)
  );

  // Three-stage synchronisers on the flash bytes
  logic [7:0] low_s1;
  logic [7:0] low_s2;
  logic [7:0] low_s3;
  logic [7:0] high_s1;
  logic [7:0] high_s2;
  logic [7:0] high_s3;
  logic [7:0] next_low_s1;
  logic [7:0] next_low_s2;
  logic [7:0] next_low_s3;
  logic [7:0] next_high_s1;
  logic [7:0] next_high_s2;
  logic [7:0] next_high_s3;

  always_comb begin
    next_low_s1 = flash_options_low;
    next_low_s2 = low_s1;
    next_low_s3 = low_s2;
    next_high_s1 = flash_options_high;
    next_high_s2 = high_s1;
    next_high_s3 = high_s2;
  end

  always_ff @(posedge clock) begin
    low_s1 <= next_low_s1;
    low_s2 <= next_low_s2;
    low_s3 <= next_low_s3;
    high_s1 <= next_high_s1;
    high_s2 <= next_high_s2;
    high_s3 <= next_high_s3;
  end

  logic bytes_agree;
  assign bytes_agree = (low_s2 == low_s3) && (high_s2 == high_s3);

  // Capture sequencing
  sob_state_t state;
  sob_state_t next_state;
  logic [`SOB_SETTLE_WIDTH-1:0] settle_count;
  logic [`SOB_SETTLE_WIDTH-1:0] next_settle_count;
  logic [7:0] held_low;
  logic [7:0] held_high;
  logic [7:0] next_held_low;
  logic [7:0] next_held_high;

  always_comb begin
    next_state = state;
    next_settle_count = settle_count;
    next_held_low = held_low;
    next_held_high = held_high;
    case (state)
      sob_st_sample: begin
        // Any disagreement restarts the settling wait
        if (!bytes_agree) begin
          next_settle_count = '0;
        end else if (settle_count == `SOB_SETTLE_CYCLES) begin
          next_held_low = low_s3;
          next_held_high = high_s3;
          next_state = sob_st_hold;
        end else begin
          next_settle_count = settle_count + 1'b1;
        end
      end
      sob_st_hold: begin
        // Flash changes are ignored until the next reset
        next_state = sob_st_hold;
      end
      default: begin
        next_state = sob_st_sample;
      end
    endcase
  end

  // Every reset re-enters sampling, so reprogrammed bytes take effect
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= sob_st_sample;
      settle_count <= '0;
      held_low <= `SOB_RESET_BYTE;
      held_high <= `SOB_RESET_BYTE;
    end else begin
      state <= next_state;
      settle_count <= next_settle_count;
      held_low <= next_held_low;
      held_high <= next_held_high;
    end
  end

  assign opt.options_low = held_low;
  assign opt.options_high = held_high;

  // Registered decoded outputs
  logic next_valid;
  logic [7:0] next_port_value;
  logic next_osc_reserved;

  always_comb begin
    next_valid = (state == sob_st_hold);
    next_port_value = opt.port_reset_level ? `SOB_PORT_HIGH : `SOB_PORT_LOW;
    next_osc_reserved = (opt.osc_source == sob_osc_reserved);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      options_valid <= 1'b0;
      watchdog_clock_select <= 1'b0;
      reset_pin_off <= 1'b0;
      port_reset_level <= 1'b0;
      port_reset_value <= `SOB_PORT_LOW;
      brownout_level_select <= sob_bod_4v5;
      crystal_filter_enable <= 1'b0;
      osc_source <= sob_osc_crystal;
      osc_reserved <= 1'b0;
      program_read_blocked <= 1'b0;
      data_read_blocked <= 1'b0;
      lock_unsupported <= 1'b0;
      pwm_hz_even <= 1'b0;
      pwm_hz_odd <= 1'b0;
    end else begin
      options_valid <= next_valid;
      watchdog_clock_select <= opt.watchdog_clock_select;
      reset_pin_off <= opt.reset_pin_off;
      port_reset_level <= opt.port_reset_level;
      port_reset_value <= next_port_value;
      brownout_level_select <= opt.brownout_level_select;
      crystal_filter_enable <= opt.crystal_filter_enable;
      osc_source <= opt.osc_source;
      osc_reserved <= next_osc_reserved;
      program_read_blocked <= opt.program_read_blocked;
      data_read_blocked <= opt.data_read_blocked;
      lock_unsupported <= opt.lock_unsupported;
      pwm_hz_even <= opt.pwm_hz_even;
      pwm_hz_odd <= opt.pwm_hz_odd;
    end
  end

  // External data move read answer, one cycle after the strobe
  logic next_rvalid;
  logic next_hit;
  logic [7:0] next_rdata;

  always_comb begin
    next_rvalid = xdata_rd;
    next_hit = 1'b0;
    next_rdata = `SOB_ZERO_BYTE;
    if (xdata_rd) begin
      if (xdata_addr == `SOB_ADDR_LOW) begin
        next_hit = 1'b1;
        next_rdata = held_low;
      end else if (xdata_addr == `SOB_ADDR_HIGH) begin
        next_hit = 1'b1;
        next_rdata = held_high;
      end else begin
        next_hit = 1'b0;
        next_rdata = `SOB_ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      xdata_rvalid <= 1'b0;
      xdata_hit <= 1'b0;
      xdata_rdata <= `SOB_ZERO_BYTE;
    end else begin
      xdata_rvalid <= next_rvalid;
      xdata_hit <= next_hit;
      xdata_rdata <= next_rdata;
    end
  end

endmodule

// ---- hw/sob_opt_if.sv ----
/*
  Carrier between the loader and its field decoder: held option bytes out,
  decoded fields back. Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface sob_opt_if;
  logic [7:0] options_low;
  logic [7:0] options_high;
  logic watchdog_clock_select;
  logic reset_pin_off;
  logic port_reset_level;
  sob_pkg::sob_bod_t brownout_level_select;
  logic crystal_filter_enable;
  sob_pkg::sob_osc_t osc_source;
  logic program_read_blocked;
  logic data_read_blocked;
  logic lock_unsupported;
  logic pwm_hz_even;
  logic pwm_hz_odd;

  modport loader (
    output options_low,
    output options_high,
    input watchdog_clock_select,
    input reset_pin_off,
    input port_reset_level,
    input brownout_level_select,
    input crystal_filter_enable,
    input osc_source,
    input program_read_blocked,
    input data_read_blocked,
    input lock_unsupported,
    input pwm_hz_even,
    input pwm_hz_odd
  );

  modport decoder (
    input options_low,
    input options_high,
    output watchdog_clock_select,
    output reset_pin_off,
    output port_reset_level,
    output brownout_level_select,
    output crystal_filter_enable,
    output osc_source,
    output program_read_blocked,
    output data_read_blocked,
    output lock_unsupported,
    output pwm_hz_even,
    output pwm_hz_odd
  );
endinterface

// ---- hw/sob_params.svh ----
/*
  Constants of the start-up option byte loader: addresses, field positions,
  reset values and timing counts. Assumes it is included by bare name.
*/
`ifndef SOB_PARAMS_SVH
`define SOB_PARAMS_SVH

// External data move addresses of the two option bytes
`define SOB_ADDR_LOW 16'hFB00
`define SOB_ADDR_HIGH 16'hFB01

// Low option byte fields
`define SOB_WDT_CLK_BIT 7
`define SOB_RST_PIN_BIT 6
`define SOB_PORT_LVL_BIT 5
`define SOB_BOD_HI_BIT 4
`define SOB_BOD_LO_BIT 3
`define SOB_XFILT_BIT 2
`define SOB_OSC_HI_BIT 1
`define SOB_OSC_LO_BIT 0

// High option byte fields
`define SOB_PLOCK_BIT 7
`define SOB_DLOCK_BIT 6
`define SOB_HZ_EVEN_BIT 1
`define SOB_HZ_ODD_BIT 0

// Holding register value from each reset until capture (erased flash)
`define SOB_RESET_BYTE 8'hFF
`define SOB_PORT_HIGH 8'hFF
`define SOB_PORT_LOW 8'h00
`define SOB_ZERO_BYTE 8'h00

// Cycles the synchronised bytes must stay steady before capture
`define SOB_SETTLE_CYCLES 2'h3
`define SOB_SETTLE_WIDTH 2

// Watchdog RC oscillator rate, in kHz
`define SOB_WDT_RC_KHZ 500

`endif

// ---- hw/sob_pkg.sv ----
/*
  Types of the start-up option byte loader.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sob_pkg;

  // Brownout threshold, in order 4.5 V, 3.8 V, 2.6 V
  typedef enum logic [1:0] {
    sob_bod_4v5,
    sob_bod_3v8,
    sob_bod_2v6
  } sob_bod_t;

  // Processor clock source, in field encoding order
  typedef enum logic [1:0] {
    sob_osc_crystal,
    sob_osc_internal_rc,
    sob_osc_reserved,
    sob_osc_external
  } sob_osc_t;

  // Loader sequencing
  typedef enum logic [0:0] {
    sob_st_sample,
    sob_st_hold
  } sob_state_t;

endpackage
